// File: hw/spu_serial_port.sv
// Second serial port: control/status and data registers plus shift engines
`timescale 1ns/1ps
// Notes on behaviour
// - Modes 1-3 frame data with one start and one stop bit: 10 or 11 bits.
// - Mode bits pick modes 0-3; mode 0 12/4 ticks, mode 2 64/32 ticks.
// - Fixed-rate tick equals system clock but halts while Idle.
// - Modes 1 and 3 bit rate comes from the timer overflow chosen by timer control.
// - Mode 1 with qualifier set raises receive-done only on a valid stop bit.
// - Modes 2/3 with qualifier set drop frames whose ninth bit is 0.
// - Receive enable gates reception; in mode 0 setting it starts one reception.
// - In modes 2 and 3 the tx ninth bit control supplies the ninth sent bit.
// - Rx ninth bit holds ninth bit in modes 2/3, stop bit in mode 1 unqualified.
// - Transmit-done sets after eighth bit in mode 0, after last data bit otherwise.
// - Receive-done sets after 8th bit in mode 0, after the whole stop bit in modes 1-3.
// - Data address writes the transmit holder and reads the receive holder.
module spu_serial_port (
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   input  wire spu_pkg::spu_bus_s bus_i,
   output logic [7:0]             rdata_o,
   input  wire logic              idle_i,
   input  wire logic [7:0]        timer_two_control_i,
   input  wire logic              baud_double_select_i,
   input  wire logic              t1_ovf_i,
   input  wire logic              t2_ovf_i,
   input  wire logic              rxd_i,
   output logic                   rxd_o,
   output logic                   rxd_oe_o,
   output logic                   txd_o
);
   typedef enum logic [1:0] {SPU_IDLE, SPU_SHIFT, SPU_DONE} spu_state_e;

   logic [7:0] ctrl_reg, ctrl_next, rbuf_reg, rbuf_next;
   logic [10:0] tsh_reg, tsh_next;
   logic [9:0] rsh_reg, rsh_next;
   logic [3:0] tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
   logic [6:0] tdiv_reg, tdiv_next, rdiv_reg, rdiv_next;
   logic [3:0] tovs_reg, tovs_next, rovs_reg, rovs_next;
   logic txd_reg, txd_next, sclk_reg, sclk_next, rx_d_reg, rx_d_next;
   spu_state_e tst_reg, tst_next, rst_reg, rst_next;
   logic [1:0] mode;
   logic qual, pclk, fix_tick, t_ovf, r_ovf, t_tick, r_tick, t_bit, r_bit, r_samp;
   logic [6:0] fdiv;
   logic [3:0] nbits;
   logic wr_ctrl, wr_data, t_set, r_set;
   logic rx_ok;

   assign mode = {ctrl_reg[spu_pkg::SPU_B_MSH], ctrl_reg[spu_pkg::SPU_B_MSL]};
   assign qual = ctrl_reg[spu_pkg::SPU_B_MQ];
   assign pclk = !idle_i;
   assign fdiv = (mode == 2'd0) ? (qual ? spu_pkg::SPU_M0_DIV_Q : spu_pkg::SPU_M0_DIV)
                 : (baud_double_select_i ? spu_pkg::SPU_M2_DIV_DBL : spu_pkg::SPU_M2_DIV);
   // Timer overflows arrive as 16x oversampling ticks
   assign t_ovf = timer_two_control_i[spu_pkg::SPU_T2_TCLK] ? t2_ovf_i : t1_ovf_i;
   assign r_ovf = timer_two_control_i[spu_pkg::SPU_T2_RCLK] ? t2_ovf_i : t1_ovf_i;
   assign nbits = (mode == 2'd0) ? spu_pkg::SPU_BITS_M0
                : (mode == 2'd1) ? spu_pkg::SPU_BITS_M1 : spu_pkg::SPU_BITS_M23;
   assign wr_ctrl = bus_i.wr && (bus_i.addr == spu_pkg::SPU_ADDR_CTRL);
   assign wr_data = bus_i.wr && (bus_i.addr == spu_pkg::SPU_ADDR_DATA);
   assign rdata_o = (bus_i.addr == spu_pkg::SPU_ADDR_DATA) ? rbuf_reg : ctrl_reg;
   assign txd_o = txd_reg;
   assign rxd_o = sclk_reg;
   assign rxd_oe_o = (mode == 2'd0) && (tst_reg == SPU_SHIFT || rst_reg == SPU_SHIFT);

   // Divided bit enables; fixed modes use pclk/fdiv, timer modes 16 overflows per bit
   always_comb begin
      tdiv_next = tdiv_reg;
      tovs_next = tovs_reg;
      t_bit = 1'b0;
      fix_tick = (mode == 2'd0) || (mode == 2'd2);
      t_tick = fix_tick ? pclk : t_ovf;
      if (tst_reg != SPU_SHIFT) begin
         tdiv_next = '0;
         tovs_next = '0;
      end else if (t_tick) begin
         if (fix_tick) begin
            tdiv_next = (tdiv_reg == fdiv - 7'd1) ? 7'd0 : tdiv_reg + 7'd1;
            t_bit = (tdiv_reg == fdiv - 7'd1);
         end else begin
            tovs_next = tovs_reg + 4'd1;
            t_bit = (tovs_reg == 4'(spu_pkg::SPU_OVS - 5'd1));
         end
      end
   end

   always_comb begin
      rdiv_next = rdiv_reg;
      rovs_next = rovs_reg;
      r_bit = 1'b0;
      r_samp = 1'b0;
      r_tick = fix_tick ? pclk : r_ovf;
      if (rst_reg != SPU_SHIFT) begin
         rdiv_next = '0;
         rovs_next = '0;
      end else if (r_tick) begin
         if (fix_tick) begin
            rdiv_next = (rdiv_reg == fdiv - 7'd1) ? 7'd0 : rdiv_reg + 7'd1;
            r_bit = (rdiv_reg == fdiv - 7'd1);
            r_samp = (rdiv_reg == (fdiv >> 1));
         end else begin
            rovs_next = rovs_reg + 4'd1;
            r_bit = (rovs_reg == 4'(spu_pkg::SPU_OVS - 5'd1));
            r_samp = (rovs_reg == spu_pkg::SPU_SAMPLE_AT);
         end
      end
   end

   // Transmit engine
   always_comb begin
      tst_next = tst_reg;
      tsh_next = tsh_reg;
      tcnt_next = tcnt_reg;
      txd_next = txd_reg;
      t_set = 1'b0;
      case (tst_reg)
         SPU_IDLE: begin
            txd_next = 1'b1;
            if (wr_data) begin
               if (mode == 2'd0)
                  tsh_next = {3'b111, bus_i.wdata};
               else if (mode == 2'd1)
                  tsh_next = {2'b11, bus_i.wdata, 1'b0};
               else
                  tsh_next = {1'b1, ctrl_reg[spu_pkg::SPU_B_TB8], bus_i.wdata, 1'b0};
               tcnt_next = '0;
               tst_next = SPU_SHIFT;
            end
         end
         SPU_SHIFT: begin
            txd_next = tsh_reg[0];
            if (t_bit) begin
               tsh_next = {1'b1, tsh_reg[10:1]};
               tcnt_next = tcnt_reg + 4'd1;
               // Flag at end of last data bit; in modes 1-3 the stop bit still goes out
               if ((mode == 2'd0 && tcnt_reg == nbits - 4'd1) ||
                   (mode != 2'd0 && tcnt_reg == nbits - 4'd2))
                  t_set = 1'b1;
               if (tcnt_reg == nbits - 4'd1)
                  tst_next = SPU_IDLE;
            end
         end
         default: tst_next = SPU_IDLE;
      endcase
   end

   // Receive engine
   always_comb begin
      rst_next = rst_reg;
      rsh_next = rsh_reg;
      rcnt_next = rcnt_reg;
      rx_d_next = rxd_i;
      sclk_next = 1'b1;
      r_set = 1'b0;
      rx_ok = 1'b0;
      case (rst_reg)
         SPU_IDLE: begin
            rcnt_next = '0;
            if (ctrl_reg[spu_pkg::SPU_B_REN] && !ctrl_reg[spu_pkg::SPU_B_RI] &&
                mode != 2'd0 && rx_d_reg && !rxd_i)
               rst_next = SPU_SHIFT;
            // Mode 0 starts on the write that raises enable, judged on the written mode
            if (wr_ctrl && !bus_i.wdata[spu_pkg::SPU_B_MSH] && !bus_i.wdata[spu_pkg::SPU_B_MSL] &&
                bus_i.wdata[spu_pkg::SPU_B_REN] && !bus_i.wdata[spu_pkg::SPU_B_RI] &&
                !ctrl_reg[spu_pkg::SPU_B_REN])
               rst_next = SPU_SHIFT;
         end
         SPU_SHIFT: begin
            if (mode == 2'd0)
               sclk_next = (rdiv_reg < (fdiv >> 1)) ? 1'b0 : 1'b1;
            if (r_samp)
               rsh_next = {rxd_i, rsh_reg[9:1]};
            if (!ctrl_reg[spu_pkg::SPU_B_REN])
               rst_next = SPU_IDLE;
            else if (r_bit) begin
               rcnt_next = rcnt_reg + 4'd1;
               if (mode != 2'd0 && rcnt_reg == 4'd0 && rsh_reg[9])
                  rst_next = SPU_IDLE;
               else if (rcnt_reg == nbits - 4'd1)
                  rst_next = SPU_DONE;
            end
         end
         SPU_DONE: begin
            rst_next = SPU_IDLE;
            if (mode == 2'd0)
               rx_ok = 1'b1;
            else if (mode == 2'd1)
               rx_ok = !qual || rsh_reg[9];
            else
               rx_ok = !qual || rsh_reg[8];
            r_set = rx_ok && !ctrl_reg[spu_pkg::SPU_B_RI];
         end
         default: rst_next = SPU_IDLE;
      endcase
   end

   // Registers; hardware set wins over a software clear in the same cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      rbuf_next = rbuf_reg;
      if (wr_ctrl)
         ctrl_next = bus_i.wdata;
      if (t_set)
         ctrl_next[spu_pkg::SPU_B_TI] = 1'b1;
      if (r_set) begin
         ctrl_next[spu_pkg::SPU_B_RI] = 1'b1;
         if (mode == 2'd0) begin
            rbuf_next = rsh_reg[9:2];
         end else if (mode == 2'd1) begin
            rbuf_next = rsh_reg[8:1];
            ctrl_next[spu_pkg::SPU_B_RB8] = rsh_reg[9];
         end else begin
            rbuf_next = rsh_reg[7:0];
            ctrl_next[spu_pkg::SPU_B_RB8] = rsh_reg[8];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         ctrl_reg <= spu_pkg::SPU_CTRL_RST;
         rbuf_reg <= spu_pkg::SPU_DATA_RST;
         tsh_reg <= '1;
         rsh_reg <= '0;
         tcnt_reg <= '0;
         rcnt_reg <= '0;
         tdiv_reg <= '0;
         rdiv_reg <= '0;
         tovs_reg <= '0;
         rovs_reg <= '0;
         txd_reg <= 1'b1;
         sclk_reg <= 1'b1;
         rx_d_reg <= 1'b1;
         tst_reg <= SPU_IDLE;
         rst_reg <= SPU_IDLE;
      end else begin
         ctrl_reg <= ctrl_next;
         rbuf_reg <= rbuf_next;
         tsh_reg <= tsh_next;
         rsh_reg <= rsh_next;
         tcnt_reg <= tcnt_next;
         rcnt_reg <= rcnt_next;
         tdiv_reg <= tdiv_next;
         rdiv_reg <= rdiv_next;
         tovs_reg <= tovs_next;
         rovs_reg <= rovs_next;
         txd_reg <= txd_next;
         sclk_reg <= sclk_next;
         rx_d_reg <= rx_d_next;
         tst_reg <= tst_next;
         rst_reg <= rst_next;
      end
   end

   property p_ti_sticky;
      @(posedge core_clk_i) disable iff (!rstn_i)
      ctrl_reg[spu_pkg::SPU_B_TI] && !wr_ctrl |=> ctrl_reg[spu_pkg::SPU_B_TI];
   endproperty
   a_ti_sticky: assert property (p_ti_sticky) else $error("tx done cleared by hw");
   property p_ti_set;
      @(posedge core_clk_i) disable iff (!rstn_i)
      t_set |=> ctrl_reg[spu_pkg::SPU_B_TI];
   endproperty
   a_ti_set: assert property (p_ti_set) else $error("tx done not set");
   property p_start_bit;
      @(posedge core_clk_i) disable iff (!rstn_i)
      (tst_reg == SPU_IDLE) && wr_data && mode != 2'd0 |=> ##1 !txd_o;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit");
   property p_mp_drop;
      @(posedge core_clk_i) disable iff (!rstn_i)
      rst_reg == SPU_DONE && mode[1] && qual && !rsh_reg[8] |-> !r_set;
   endproperty
   a_mp_drop: assert property (p_mp_drop) else $error("address filter failed");
   property p_stop_valid;
      @(posedge core_clk_i) disable iff (!rstn_i)
      rst_reg == SPU_DONE && mode == 2'd1 && qual && !rsh_reg[9] |-> !r_set;
   endproperty
   a_stop_valid: assert property (p_stop_valid) else $error("bad stop accepted");
   property p_ren_off;
      @(posedge core_clk_i) disable iff (!rstn_i)
      !ctrl_reg[spu_pkg::SPU_B_REN] && rst_reg == SPU_IDLE && !wr_ctrl |=> rst_reg == SPU_IDLE;
   endproperty
   a_ren_off: assert property (p_ren_off) else $error("rx started while disabled");
   property p_ri_set;
      @(posedge core_clk_i) disable iff (!rstn_i)
      r_set |=> ctrl_reg[spu_pkg::SPU_B_RI];
   endproperty
   a_ri_set: assert property (p_ri_set) else $error("rx done not set");
   property p_rb8;
      @(posedge core_clk_i) disable iff (!rstn_i)
      r_set && mode[1] |=> ctrl_reg[spu_pkg::SPU_B_RB8] == $past(rsh_reg[8]);
   endproperty
   a_rb8: assert property (p_rb8) else $error("ninth bit not captured");
   c_tx: cover property (@(posedge core_clk_i) t_set);
   c_rx: cover property (@(posedge core_clk_i) r_set);
   c_m3: cover property (@(posedge core_clk_i) r_set && mode == 2'd3);
endmodule

// File: hw/spu_pkg.sv
// Package for the second serial port: register map, fields, timing and types
package spu_pkg;
   localparam logic [7:0] SPU_ADDR_CTRL = 8'h00_C0;
   localparam logic [7:0] SPU_ADDR_DATA = 8'h00_C1;
   localparam logic [7:0] SPU_CTRL_RST  = 8'h00_00;
   localparam logic [7:0] SPU_DATA_RST  = 8'h00_00;
   localparam int SPU_B_MSH = 7;
   localparam int SPU_B_MSL = 6;
   localparam int SPU_B_MQ  = 5;
   localparam int SPU_B_REN = 4;
   localparam int SPU_B_TB8 = 3;
   localparam int SPU_B_RB8 = 2;
   localparam int SPU_B_TI  = 1;
   localparam int SPU_B_RI  = 0;
   localparam logic [6:0] SPU_M0_DIV     = 7'd12;
   localparam logic [6:0] SPU_M0_DIV_Q   = 7'd4;
   localparam logic [6:0] SPU_M2_DIV     = 7'd64;
   localparam logic [6:0] SPU_M2_DIV_DBL = 7'd32;
   localparam logic [4:0] SPU_OVS        = 5'd16;
   localparam logic [3:0] SPU_SAMPLE_AT  = 4'd8;
   localparam logic [3:0] SPU_BITS_M0    = 4'd8;
   localparam logic [3:0] SPU_BITS_M1    = 4'd10;
   localparam logic [3:0] SPU_BITS_M23   = 4'd11;
   localparam int SPU_T2_RCLK = 5;
   localparam int SPU_T2_TCLK = 4;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } spu_bus_s;
endpackage

// File: test/spu_remote_model.sv
// Remote serial device: sends frames on the receive line and catches transmitted frames
`timescale 1ns/1ps
module spu_remote_model (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   int bit_cyc = 32;

   // Line idles high between frames, as an asynchronous link does
   initial rxd_o = 1'b1;

   // One start bit, data LSB first, one stop bit; stop may be sent bad on purpose
   task automatic send(input logic [8:0] data, input int nbits, input logic stop);
      int i;
      rxd_o <= 1'b0;
      repeat (bit_cyc) @(posedge clk_i);
      for (i = 0; i < nbits; i++) begin
         rxd_o <= data[i];
         repeat (bit_cyc) @(posedge clk_i);
      end
      rxd_o <= stop;
      repeat (bit_cyc) @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask

   // Samples each bit in its middle, counted from the falling start edge
   task automatic catch_frame(input int nbits, output logic [8:0] data, output logic stop);
      int i;
      int w;
      data = '0;
      w = 0;
      while (txd_i !== 1'b0 && w < 4000) begin
         @(posedge clk_i);
         w++;
      end
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (i = 0; i < nbits; i++) begin
         repeat (bit_cyc) @(posedge clk_i);
         data[i] = txd_i;
      end
      repeat (bit_cyc) @(posedge clk_i);
      // A frame that never started reads as an unknown stop bit
      stop = (w < 4000) ? txd_i : 1'bx;
   endtask
endmodule

// File: test/serial_port_one_usart_tb_top.sv
// Bench for the second serial port: register access and frames in both directions
`timescale 1ns/1ps
module serial_port_one_usart_tb_top;
   logic              core_clk;
   logic              rstn;
   spu_pkg::spu_bus_s bus;
   logic [7:0]        rdata;
   logic [7:0]        t2ctl;
   logic              t1_ovf;
   logic              t2_ovf;
   logic              rxd_wire;
   logic              remote_rxd;
   logic              shclk;
   logic              shclk_oe;
   logic              txd;
   logic              idle;
   logic              dbl;
   int                fail_count;
   int                comparisons;
   int                seed;
   int                cyc;
   int                i;
   int                nb;
   int                len;
   logic [8:0]        got;
   logic              stp;
   logic              dn;
   logic              oe_seen;
   logic [7:0]        b;
   logic [7:0]        x;
   logic [7:0]        ctl;
   logic [7:0]        last;
   logic [7:0]        tx_ctl [4] = '{8'h40, 8'hC8, 8'h80, 8'h88};
   logic [7:0]        tx_t2 [4]  = '{8'h00, 8'h30, 8'h00, 8'h00};
   int                tx_cyc [4] = '{32, 64, 32, 64};
   logic              tx_dbl [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0]        rx_ctl [6] = '{8'h50, 8'h70, 8'hF0, 8'hF0, 8'h90, 8'h40};
   logic              rx_n9 [6]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   logic              rx_st [6]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

   // Shared receive pin: the port drives it only while its enable is high
   assign rxd_wire = shclk_oe ? shclk : remote_rxd;

   spu_serial_port spu_serial_port_i (
      .core_clk_i          (core_clk),
      .rstn_i              (rstn),
      .bus_i               (bus),
      .rdata_o             (rdata),
      .idle_i              (idle),
      .timer_two_control_i (t2ctl),
      .baud_double_select_i(dbl),
      .t1_ovf_i            (t1_ovf),
      .t2_ovf_i            (t2_ovf),
      .rxd_i               (rxd_wire),
      .rxd_o               (shclk),
      .rxd_oe_o            (shclk_oe),
      .txd_o               (txd)
   );

   spu_remote_model spu_remote_model_i (
      .clk_i(core_clk),
      .txd_i(txd),
      .rxd_o(remote_rxd)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Timer one overflows every 2 cycles, timer two every 4, so a wrong pick shows
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      t1_ovf <= (cyc % 2 == 1);
      t2_ovf <= (cyc % 4 == 3);
   end

   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus.addr <= a;
      #1 d = rdata;
   endtask

   // Reference for the receive flag, from mode, qualifier and received bits
   function automatic logic exp_done(input logic [7:0] c, input logic n9, input logic st);
      if (!c[spu_pkg::SPU_B_REN]) return 1'b0;
      if (c[7:6] == 2'b01) return !c[5] || st;
      return !c[5] || n9;
   endfunction

   task automatic results;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      results();
   end

   initial begin
      seed = 32'ha26d;
      cyc = 0;
      t1_ovf = 1'b0;
      t2_ovf = 1'b0;
      rstn = 1'b0;
      bus = '0;
      t2ctl = '0;
      idle = 1'b0;
      dbl = 1'b1;
      last = spu_pkg::SPU_DATA_RST;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rd(spu_pkg::SPU_ADDR_CTRL, x);
      chk("ctrl_reset", {1'b0, x}, {1'b0, spu_pkg::SPU_CTRL_RST});
      rd(spu_pkg::SPU_ADDR_DATA, x);
      chk("data_reset", {1'b0, x}, {1'b0, spu_pkg::SPU_DATA_RST});
      chk("oe_idle", {8'h00, shclk_oe}, 9'h000);
      // Modes 1, 3 (timer two), 2 at both rates; control write clears done
      for (i = 0; i < 4; i++) begin
         ctl = tx_ctl[i];
         nb = ctl[7] ? 9 : 8;
         t2ctl <= tx_t2[i];
         dbl <= tx_dbl[i];
         spu_remote_model_i.bit_cyc = tx_cyc[i];
         wr(spu_pkg::SPU_ADDR_CTRL, ctl);
         b = $random(seed);
         fork
            spu_remote_model_i.catch_frame(nb, got, stp);
            wr(spu_pkg::SPU_ADDR_DATA, b);
         join
         chk("tx_frame", got, {(nb == 9) & ctl[3], b});
         chk("tx_stop", {8'h00, stp}, 9'h001);
         rd(spu_pkg::SPU_ADDR_CTRL, x);
         // Done must already stand in mid stop bit
         chk("tx_done", {8'h00, x[spu_pkg::SPU_B_TI]}, 9'h001);
         // Let the stop bit finish; a data write while still shifting is ignored
         repeat (tx_cyc[i]) @(posedge core_clk);
      end
      // Receive cases: accepted, bad stop, ninth bit filter, enable off
      t2ctl <= 8'h00;
      dbl <= 1'b1;
      spu_remote_model_i.bit_cyc = 32;
      for (i = 0; i < 6; i++) begin
         ctl = rx_ctl[i];
         nb = ctl[7] ? 9 : 8;
         wr(spu_pkg::SPU_ADDR_CTRL, ctl);
         b = $random(seed);
         spu_remote_model_i.send({rx_n9[i], b}, nb, rx_st[i]);
         repeat (4) @(posedge core_clk);
         dn = exp_done(ctl, rx_n9[i], rx_st[i]);
         rd(spu_pkg::SPU_ADDR_CTRL, x);
         chk("rx_done", {8'h00, x[spu_pkg::SPU_B_RI]}, {8'h00, dn});
         if (dn) begin
            last = b;
            chk("rx_ninth", {8'h00, x[2]}, {8'h00, (ctl[7:6] == 2'b01) ? rx_st[i] : rx_n9[i]});
         end
         rd(spu_pkg::SPU_ADDR_DATA, x);
         chk("rx_data", {1'b0, x}, {1'b0, last});
      end
      // Mode 0: raising enable starts one 8-bit shift; Idle freezes the tick for 24 cycles
      for (i = 0; i < 2; i++) begin
         wr(spu_pkg::SPU_ADDR_CTRL, 8'h00);
         wr(spu_pkg::SPU_ADDR_CTRL, i ? 8'h30 : 8'h10);
         len = spu_pkg::SPU_BITS_M0 * (i ? spu_pkg::SPU_M0_DIV_Q : spu_pkg::SPU_M0_DIV);
         len = len + (i ? 0 : 24);
         nb = 0;
         x = '0;
         oe_seen = 1'b0;
         while (x[spu_pkg::SPU_B_RI] !== 1'b1 && nb < 400) begin
            idle <= (i == 0) && (nb >= 10) && (nb < 34);
            rd(spu_pkg::SPU_ADDR_CTRL, x);
            nb++;
            oe_seen = oe_seen | shclk_oe;
         end
         chk("m0_oe", {8'h00, oe_seen}, 9'h001);
         chk("m0_len", {8'h00, nb >= len && nb <= len + 4}, 9'h001);
      end
      results();
   end
endmodule
